/* rtl/synth_serial_program_port.sv */
// serial programming port and control registers of a triple-pll synthesizer
// assumes serial pins and powerdown pin are asynchronous; ticks are on i_clk
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - word is 4-bit address plus 18-bit data
// - enable low: shift data on clock rise
// - enable rise: copy data to addressed register
// - enable high: shift register left untouched
// - extra leading bits drop, last 22 kept
// - one rf pll active, last written wins
// - self-tune on powerup or frequency change
// - if pll powers down by pin or software
// - if output divides by 1, 2, 4, 8
// - r or n write selects that rf pll
// - thirteen update periods of self-tuning
module synth_serial_program_port (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_shift_clk,
  input wire logic i_shift_data_in,
  input wire logic i_serial_load_enable_low,
  input wire logic i_powerdown_pin,
  input wire logic i_pd_update_tick,
  input wire logic i_if_vco_tick,
  output logic o_rf_high_band,
  output logic o_rf_powered,
  output logic o_if_powered,
  output logic o_rf_tuning,
  output logic o_if_tuning,
  output logic [synth_prog_pkg::IF_OUTPUT_DIVIDER_W-1:0] o_if_div_ratio,
  output logic o_if_div_tick
);
  import synth_prog_pkg::*;

  // ***********************************
  // decode helpers
  // ***********************************
  function automatic logic is_rf_hi(input logic [ADDR_W-1:0] a);
    return (a == ADDR_N_HI) || (a == ADDR_R_HI);
  endfunction

  function automatic logic is_rf_lo(input logic [ADDR_W-1:0] a);
    return (a == ADDR_N_LO) || (a == ADDR_R_LO);
  endfunction

  function automatic logic is_if(input logic [ADDR_W-1:0] a);
    return (a == ADDR_N_IF) || (a == ADDR_R_IF);
  endfunction

  // ***********************************
  // pin synchronisers
  // ***********************************
  logic [3:0] pins_s;
  logic sclk_s;
  logic shift_data_in_s;
  logic sen_low_s;
  logic powerdown_pin_s;
  // enable idles high; powerdown resets low so powerup is seen after reset
  localparam logic [3:0] PIN_IDLE = 4'h4;

  pin_sync #(.WIDTH(4), .RESET_VAL(PIN_IDLE)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_powerdown_pin, i_serial_load_enable_low, i_shift_data_in, i_shift_clk}),
    .o_sync(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign shift_data_in_s = pins_s[1];
  assign sen_low_s = pins_s[2];
  assign powerdown_pin_s = pins_s[3];

  // ***********************************
  // shifter and register file
  // ***********************************
  logic sclk_prev_q, sclk_prev_d;
  logic sen_prev_q, sen_prev_d;
  logic [WORD_W-1:0] shift_q, shift_d;
  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic [DATA_W-1:0] regs_d [NUM_REGS];
  logic rf_hi_q, rf_hi_d;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic wr;
  logic chg_rf;
  logic chg_if;

  always_comb begin
    sclk_prev_d = sclk_s;
    sen_prev_d = sen_low_s;
    shift_d = shift_q;
    // edges seen by the core clock; a 22-bit window keeps only the last bits
    if (!sen_low_s && sclk_s && !sclk_prev_q) begin
      shift_d = {shift_q[WORD_W-2:0], shift_data_in_s};
    end // held otherwise, including while enable is high
    wr_addr = shift_q[WORD_W-1:DATA_W];
    wr_data = shift_q[DATA_W-1:0];
    // latch uses the shifter state; host keeps clock idle here
    wr = sen_low_s && !sen_prev_q;
    regs_d = regs_q;
    if (wr) begin
      regs_d[wr_addr] = wr_data;
    end
    rf_hi_d = rf_hi_q;
    if (wr && is_rf_hi(wr_addr)) begin
      rf_hi_d = 1'b1;
    end else if (wr && is_rf_lo(wr_addr)) begin
      rf_hi_d = 1'b0;
    end
    // a band switch counts as a new rf frequency
    chg_rf = wr && (is_rf_hi(wr_addr) || is_rf_lo(wr_addr))
      && ((wr_data != regs_q[wr_addr]) || (rf_hi_d != rf_hi_q));
    chg_if = wr && is_if(wr_addr) && (wr_data != regs_q[wr_addr]);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev_q <= 1'b0;
      sen_prev_q <= 1'b1;
      shift_q <= '0;
      rf_hi_q <= 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= (i == int'(ADDR_PWR)) ? PWR_RESET : REG_RESET;
      end
    end else begin
      sclk_prev_q <= sclk_prev_d;
      sen_prev_q <= sen_prev_d;
      shift_q <= shift_d;
      rf_hi_q <= rf_hi_d;
      regs_q <= regs_d;
    end
  end

  // ***********************************
  // power and self-tuning
  // ***********************************
  logic [NUM_TUNERS-1:0] on_d;
  logic [NUM_TUNERS-1:0] on_q;
  logic [NUM_TUNERS-1:0] chg;
  logic [NUM_TUNERS-1:0] tuning_d;
  logic [NUM_TUNERS-1:0] tuning_q;

  // pin and software bit must both allow power
  assign on_d[TUNER_RF] = powerdown_pin_s && regs_d[ADDR_PWR][PWR_RF_BIT];
  assign on_d[TUNER_IF] = powerdown_pin_s && regs_d[ADDR_PWR][PWR_IF_BIT];
  assign chg[TUNER_RF] = chg_rf;
  assign chg[TUNER_IF] = chg_if;

  genvar g;
  generate
    for (g = 0; g < NUM_TUNERS; g++) begin : g_tune
      logic [TUNE_CNT_W-1:0] cnt_q, cnt_d;

      always_comb begin
        cnt_d = cnt_q;
        if (!on_d[g]) begin
          cnt_d = '0;
        end else if (!on_q[g] || chg[g]) begin
          cnt_d = TUNE_PERIODS;
        end else if (i_pd_update_tick && (cnt_q != '0)) begin
          cnt_d = cnt_q - 1'b1;
        end
        tuning_d[g] = (cnt_d != '0);
      end

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_q <= '0;
      tuning_q <= '0;
    end else begin
      on_q <= on_d;
      tuning_q <= tuning_d;
    end
  end

  // ***********************************
  // if output divider
  // ***********************************
  logic [DIV_CNT_W-1:0] div_cnt_q, div_cnt_d;
  logic [DIV_CNT_W-1:0] div_last;
  logic div_tick_q, div_tick_d;
  logic [IF_OUTPUT_DIVIDER_W-1:0] ratio_q, ratio_d;

  always_comb begin
    ratio_d = regs_q[ADDR_MAIN][IF_OUTPUT_DIVIDER_LSB +: IF_OUTPUT_DIVIDER_W];
    div_last = DIV_CNT_W'((1 << ratio_q) - 1);
    div_cnt_d = div_cnt_q;
    div_tick_d = 1'b0;
    // counter parked while off so the first pulse after powerup is clean
    if (!on_q[TUNER_IF]) begin
      div_cnt_d = '0;
    end else if (i_if_vco_tick) begin
      if (div_cnt_q >= div_last) begin
        div_cnt_d = '0;
        div_tick_d = 1'b1;
      end else begin
        div_cnt_d = div_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_q <= '0;
      div_tick_q <= 1'b0;
      ratio_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_d;
      div_tick_q <= div_tick_d;
      ratio_q <= ratio_d;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign o_rf_high_band = rf_hi_q;
  assign o_rf_powered = on_q[TUNER_RF];
  assign o_if_powered = on_q[TUNER_IF];
  assign o_rf_tuning = tuning_q[TUNER_RF];
  assign o_if_tuning = tuning_q[TUNER_IF];
  assign o_if_div_ratio = ratio_q;
  assign o_if_div_tick = div_tick_q;
endmodule
`default_nettype wire

/* inc/synth_prog_pkg.sv */
// constants for the synthesizer serial programming port
// assumes one core clock; the serial pins are asynchronous to it
package synth_prog_pkg;
  localparam int WORD_W = 22;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 18;
  localparam int NUM_REGS = 16;
  localparam int SYNC_STAGES = 2;
  localparam int DIV_CNT_W = 3;
  localparam int TUNE_CNT_W = 4;
  localparam int IF_OUTPUT_DIVIDER_W = 2;
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_MAIN = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PWR = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_N_HI = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_N_LO = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_N_IF = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_R_HI = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_R_LO = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_R_IF = 4'h8;
  // field positions
  localparam int PWR_RF_BIT = 0;
  localparam int PWR_IF_BIT = 1;
  localparam int IF_OUTPUT_DIVIDER_LSB = 10;
  // reset values: both plls enabled by software, pin decides
  localparam logic [DATA_W-1:0] PWR_RESET = 18'h00003;
  localparam logic [DATA_W-1:0] REG_RESET = 18'h00000;
  // phase detector update periods spent self-tuning
  localparam logic [TUNE_CNT_W-1:0] TUNE_PERIODS = 4'hd;
  // tuner indices
  localparam int TUNER_RF = 0;
  localparam int TUNER_IF = 1;
  localparam int NUM_TUNERS = 2;
endpackage

/* rtl/pin_sync.sv */
// two-flop synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level relative to i_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // reset to the idle level so no false edge follows reset
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

/* bench/synth_port_monitor.sv */
// checker for the synthesizer programming port outputs
// assumes it is bound onto the port module and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
module synth_port_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_serial_load_enable_low,
  input wire logic i_powerdown_pin,
  input wire logic i_if_vco_tick,
  input wire logic o_rf_high_band,
  input wire logic o_rf_powered,
  input wire logic o_if_powered,
  input wire logic o_rf_tuning,
  input wire logic o_if_tuning,
  input wire logic [synth_prog_pkg::IF_OUTPUT_DIVIDER_W-1:0] o_if_div_ratio,
  input wire logic o_if_div_tick
);
  import synth_prog_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ****
  // sequences
  // ****
  sequence s_latch;
    !i_serial_load_enable_low ##1 i_serial_load_enable_low;
  endsequence
  // long enough idle that any pending latch has landed
  sequence s_idle;
    i_serial_load_enable_low [*8];
  endsequence
  // ****
  // assertions
  // ****
  AST_IDLE_HOLD: assert property (s_idle |-> $stable(o_rf_high_band))
    else $error("band moved while load enable idle");
  AST_BAND_LATCH: assert property ($changed(o_rf_high_band) |->
    $past(i_serial_load_enable_low, 2) && !$past(i_serial_load_enable_low, 7))
    else $error("band moved without a latch");
  AST_BAND_RETUNE: assert property ($changed(o_rf_high_band) && o_rf_powered |->
    ##[0:1] o_rf_tuning) else $error("band switch did not retune");
  AST_IF_PWR_TUNE: assert property ($rose(o_if_powered) |-> o_if_tuning)
    else $error("if powerup without tuning");
  AST_RF_PWR_TUNE: assert property ($rose(o_rf_powered) |-> o_rf_tuning)
    else $error("rf powerup without tuning");
  AST_PIN_DOWN: assert property (!i_powerdown_pin [*4] |-> !o_rf_powered && !o_if_powered)
    else $error("powered while pin low");
  AST_DIV_CAUSE: assert property (o_if_div_tick |-> $past(i_if_vco_tick))
    else $error("divider tick without input tick");
  AST_DIV_ONE: assert property (i_if_vco_tick && o_if_powered && o_if_div_ratio == 2'h0 &&
    $stable(o_if_div_ratio) |=> o_if_div_tick || !o_if_powered) else $error("divide by one");
  COV_LATCH: cover property (s_latch);
endmodule
bind synth_serial_program_port synth_port_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_serial_load_enable_low(i_serial_load_enable_low), .i_powerdown_pin(i_powerdown_pin),
  .i_if_vco_tick(i_if_vco_tick), .o_rf_high_band(o_rf_high_band), .o_rf_powered(o_rf_powered),
  .o_if_powered(o_if_powered), .o_rf_tuning(o_rf_tuning), .o_if_tuning(o_if_tuning),
  .o_if_div_ratio(o_if_div_ratio), .o_if_div_tick(o_if_div_tick));
`default_nettype wire

/* bench/serial_host_model.sv */
// host controller model driving the three serial lines
// assumes the core clock paces it; 8 cycles per shift clock period
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_shift_data_in,
  output logic o_sen_n
);
  initial {o_sclk, o_shift_data_in, o_sen_n} = 3'b001;
  // n above 22 sends extra leading bits
  task automatic send(input logic [24:0] w, input int n);
    @(posedge i_clk);
    o_sen_n <= 1'b0;
    for (int b = n - 1; b >= 0; b--) begin
      o_shift_data_in <= w[b];
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
    o_sclk <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_sen_n <= 1'b1;
    // released line shows no stale bit
    o_shift_data_in <= ~o_shift_data_in;
    repeat (8) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* bench/test_synth_serial_program_port.sv */
// self-checking bench for the synthesizer programming port
// assumes host model and bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_synth_serial_program_port;
  import synth_prog_pkg::*;
  logic clk = 1'b0, rst = 1'b1, pin = 1'b1, pd_tick = 1'b0, vco_tick = 1'b0, vco_en = 1'b0;
  wire logic sclk, shift_data_in, sen_n, hb, rf_pw, if_pw, rf_tn, if_tn, div_tick;
  wire logic [IF_OUTPUT_DIVIDER_W-1:0] ratio;
  int n_mismatch = 0, cmp_count = 0;
  always #50 clk = ~clk;
  always @(posedge clk) vco_tick <= vco_en & ~vco_tick;
  serial_host_model u_serial_host_model (.i_clk(clk), .o_sclk(sclk), .o_shift_data_in(shift_data_in),
    .o_sen_n(sen_n));
  synth_serial_program_port u_synth_serial_program_port (.i_clk(clk), .i_rst(rst),
    .i_shift_clk(sclk), .i_shift_data_in(shift_data_in), .i_serial_load_enable_low(sen_n),
    .i_powerdown_pin(pin), .i_pd_update_tick(pd_tick), .i_if_vco_tick(vco_tick),
    .o_rf_high_band(hb), .o_rf_powered(rf_pw), .o_if_powered(if_pw), .o_rf_tuning(rf_tn),
    .o_if_tuning(if_tn), .o_if_div_ratio(ratio), .o_if_div_tick(div_tick));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [24:0] w, input int n);
    u_serial_host_model.send(w, n);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) pd_tick <= 1'b1;
      @(posedge clk) pd_tick <= 1'b0;
    end
    @(posedge clk);
    #1;
  endtask
  task automatic s_startup;
    repeat (4) @(posedge clk);
    #1;
    check("startup", 8'({if_pw, rf_tn, if_tn}), 8'h07);
    tick(12);
    check("still tuning", 8'(rf_tn), 8'h01);
    tick(1);
    check("tune done", 8'({rf_tn, if_tn}), 8'h00);
  endtask
  task automatic s_band;
    wr({3'h0, ADDR_N_LO, 18'h00123}, 22);
    check("band tune", 8'({hb, rf_tn}), 8'h01);
    tick(13);
    // three leading bits must drop, leaving a high-band r write
    wr({3'h5, ADDR_R_HI, 18'h00456}, 25);
    check("band", 8'({hb, rf_tn}), 8'h03);
    tick(13);
    wr({3'h0, ADDR_N_IF, 18'h00789}, 22);
    check("if retune", 8'({rf_tn, if_tn}), 8'h01);
    tick(13);
    // same value again is no frequency change
    wr({3'h0, ADDR_N_IF, 18'h00789}, 22);
    check("if same value", 8'({rf_tn, if_tn}), 8'h00);
  endtask
  task automatic s_div;
    int cnt;
    @(posedge clk) vco_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr({3'h0, ADDR_MAIN, 18'(k << IF_OUTPUT_DIVIDER_LSB)}, 22);
      cnt = 0;
      repeat (32) begin
        @(posedge clk);
        #1;
        if (div_tick === 1'b1) cnt++;
      end
      check("ratio", 8'(ratio), 8'(k));
      check("div ticks", 8'(cnt), 8'(16 >> k));
    end
  endtask
  task automatic s_power;
    wr({3'h0, ADDR_PWR, 18'h00001}, 22);
    check("pwr rf only", 8'({rf_pw, if_pw}), 8'h02);
    wr({3'h0, ADDR_PWR, 18'h00003}, 22);
    check("if soft tune", 8'({if_pw, if_tn}), 8'h03);
    @(posedge clk) pin <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("pin down", 8'({rf_pw, if_pw}), 8'h00);
    @(posedge clk) pin <= 1'b1;
    tick(2);
    check("pin up tune", 8'({rf_tn, if_tn}), 8'h03);
  endtask
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    s_startup();
    s_band();
    s_div();
    s_power();
    test_done();
  end
endmodule
`default_nettype wire
